// ### bcg_pkg.sv
// constants shared by the block check front end
// assumes one 200 MHz clock and a host doing word accesses
package bcg_pkg;
  // register selects, from address lines 2:1
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_ACC  = 2'h1;
  localparam logic [1:0] SEL_DATA = 2'h2;
  // control_status field positions
  localparam int MODE_LSB   = 0;
  localparam int MODE_W     = 3;
  localparam int DBL_BIT    = 3;
  localparam int CLEAR_BIT  = 4;
  localparam int STEP_BIT   = 5;
  localparam int AUTO_BIT   = 6;
  localparam int DONE_BIT   = 7;
  localparam int QUO_BIT    = 8;
  localparam int USED_BITS  = 9;
  // reset values
  localparam logic [2:0]  MODE_RST  = 3'h0;
  localparam logic [15:0] DATA_RST  = 16'h0000;
  // polynomial codes
  localparam logic [2:0] MODE_CRC12 = 3'h0;
  localparam logic [2:0] MODE_CRC16 = 3'h1;
  localparam logic [2:0] MODE_LRC8  = 3'h2;
  localparam logic [2:0] MODE_LRC16 = 3'h3;
  // character lengths in bits
  localparam logic [4:0] CHAR_BITS_6 = 5'h06;
  localparam logic [4:0] CHAR_BITS_8 = 5'h08;
  localparam int STAGE_W  = 4;
  localparam int DATA_W   = 16;
endpackage

// ### bcg_fifo2.sv
// two-entry buffer between host data writes and the data register
// assumes one clock; the drain side may stall at will
`timescale 1ns/1ps
module bcg_fifo2 #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_overrun : assert property (@(posedge clk) disable iff (!rst_b)
    cnt_q <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

// ### bcg_csr_data.sv
// control_status and shift_data registers of the block check generator
// assumes the host strobes rd/wr for one cycle with a register select;
// the feedback network and accumulator sit outside and take serial_bit
`timescale 1ns/1ps
// Function
// - 16-bit control_status, nine low bits used
// - bits 0-3,6 rw; 7,8 read; 4,5 write
// - 16-bit write-only shift_data register
// - double_byte_select picks one or two characters
// - right-justified data, shift count from polynomial
// - four 4-bit stages, clear, load, shift
// - stage low bit feeds next lower stage
// - serial output taken from bit 0
// - mode bits 2:0 select polynomial
// - clear zeroes accumulator, sets load-ready
// - load-ready set on done/clear/init, cleared by load
// - auto_shift_enable: each load runs full cycle
// - step shifts once while auto shift off
module bcg_csr_data #(
  parameter int DATA_W = bcg_pkg::DATA_W
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // host register port
  input  wire logic [1:0]        reg_sel,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [15:0]       reg_wdata,
  output logic [15:0]            reg_rdata,
  output logic                   data_wr_ready,
  // accumulator side
  input  wire logic [15:0]       acc_value,
  input  wire logic              quotient_bit,
  input  wire logic              feedback_ready,
  output logic                   serial_bit,
  output logic                   shift_pulse,
  output logic                   accumulator_clear,
  output logic [2:0]             poly_mode,
  output logic                   wide_check_bit
);
  logic [2:0]        mode_q;
  logic              double_byte_select_q;
  logic              auto_shift_enable_q;
  logic              done_q;
  logic [4:0]        count_q;
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] data_d;
  logic [15:0]       rdata_q;
  logic              clear_q;
  logic              ctrl_wr;
  logic              data_wr;
  logic              clear_cmd;
  logic              step_cmd;
  logic              shift_now;
  logic              load_now;
  logic              fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic [4:0]        char_bits;
  logic [4:0]        target;

  assign ctrl_wr   = reg_wr & (reg_sel == bcg_pkg::SEL_CTRL);
  assign data_wr   = reg_wr & (reg_sel == bcg_pkg::SEL_DATA);
  assign clear_cmd = ctrl_wr & reg_wdata[bcg_pkg::CLEAR_BIT];
  // step ignored unless auto shift is off after this write
  assign step_cmd  = ctrl_wr & reg_wdata[bcg_pkg::STEP_BIT]
                   & ~reg_wdata[bcg_pkg::AUTO_BIT];

  // CRC-12 uses six-bit characters; the rest eight
  assign char_bits = (mode_q == bcg_pkg::MODE_CRC12)
                   ? bcg_pkg::CHAR_BITS_6
                   : bcg_pkg::CHAR_BITS_8;
  assign target    = double_byte_select_q ? 5'(char_bits << 1)
                                          : char_bits;

  // a stalled feedback network holds an auto shift, no bit lost; a step during a stall is dropped
  assign shift_now = ~done_q & feedback_ready & ~clear_cmd
                   & (auto_shift_enable_q | step_cmd);
  // clear wins over a load in the same cycle
  assign load_now  = done_q & fifo_valid & ~clear_cmd;

  bcg_fifo2 #(
    .WIDTH (DATA_W),
    .DEPTH (2)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (data_wr),
    .in_ready  (data_wr_ready),
    .in_data   (reg_wdata[DATA_W-1:0]),
    .out_valid (fifo_valid),
    .out_ready (load_now),
    .out_data  (fifo_data)
  );

  // control bits: rw fields, init clears them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q               <= bcg_pkg::MODE_RST;
      double_byte_select_q <= 1'b0;
      auto_shift_enable_q  <= 1'b0;
    end else if (ctrl_wr) begin
      mode_q <= reg_wdata[bcg_pkg::MODE_LSB +: bcg_pkg::MODE_W];
      double_byte_select_q <= reg_wdata[bcg_pkg::DBL_BIT];
      auto_shift_enable_q  <= reg_wdata[bcg_pkg::AUTO_BIT];
    end
  end

  // load-ready flag and shift count; setting wins over the load
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q  <= 1'b1;
      count_q <= '0;
    end else if (clear_cmd) begin
      done_q  <= 1'b1;
      count_q <= '0;
    end else if (shift_now) begin
      count_q <= count_q + 5'h01;
      if (count_q + 5'h01 >= target) begin
        done_q  <= 1'b1;
        count_q <= '0;
      end
    end else if (load_now) begin
      done_q <= 1'b0;
    end
  end

  // four 4-bit stages, each stage bit 0 feeds the stage below
  for (genvar s = 0; s < DATA_W / bcg_pkg::STAGE_W; s++) begin : g_stage
    localparam int LO = s * bcg_pkg::STAGE_W;
    logic ser_in;
    if (s == DATA_W / bcg_pkg::STAGE_W - 1) begin : g_top
      assign ser_in = 1'b0;
    end else begin : g_mid
      assign ser_in = data_q[LO + bcg_pkg::STAGE_W];
    end
    always_comb begin
      if (load_now) begin
        data_d[LO +: bcg_pkg::STAGE_W] = fifo_data[LO +: bcg_pkg::STAGE_W];
      end else if (shift_now) begin
        data_d[LO +: bcg_pkg::STAGE_W] =
          {ser_in, data_q[LO + 1 +: bcg_pkg::STAGE_W - 1]};
      end else begin
        data_d[LO +: bcg_pkg::STAGE_W] = data_q[LO +: bcg_pkg::STAGE_W];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= bcg_pkg::DATA_RST;
    end else begin
      data_q <= data_d;
    end
  end

  // strobes to the accumulator, one cycle each
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= clear_cmd;
    end
  end

  // serial bit presented with its shift strobe, from bit 0
  assign serial_bit        = data_q[0];
  assign shift_pulse       = shift_now;
  assign accumulator_clear = clear_q;
  assign poly_mode         = mode_q;
  assign wide_check_bit    = mode_q[0];

  // read data: one cycle after the strobe; shift_data never answers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      rdata_q <= 16'h0000;
      if (reg_sel == bcg_pkg::SEL_CTRL) begin
        rdata_q[bcg_pkg::MODE_LSB +: bcg_pkg::MODE_W] <= mode_q;
        rdata_q[bcg_pkg::DBL_BIT]  <= double_byte_select_q;
        rdata_q[bcg_pkg::AUTO_BIT] <= auto_shift_enable_q;
        rdata_q[bcg_pkg::DONE_BIT] <= done_q;
        rdata_q[bcg_pkg::QUO_BIT]  <= quotient_bit;
      end else if (reg_sel == bcg_pkg::SEL_ACC) begin
        rdata_q <= acc_value;
      end
    end
  end
  assign reg_rdata = rdata_q;

  // checks
  a_clear_sets_done : assert property (
    @(posedge clk) disable iff (!rst_b)
    clear_cmd |=> done_q && accumulator_clear)
    else $error("clear did not set done and pulse clear");
  a_load_clears_done : assert property (
    @(posedge clk) disable iff (!rst_b)
    load_now |=> !done_q && data_q == $past(fifo_data))
    else $error("load did not clear done or capture data");
  a_no_shift_done : assert property (
    @(posedge clk) disable iff (!rst_b)
    done_q |-> !shift_pulse)
    else $error("shift while load-ready");
  a_shift_moves_right : assert property (
    @(posedge clk) disable iff (!rst_b)
    shift_now |=> data_q == {1'b0, $past(data_q[DATA_W-1:1])})
    else $error("shift did not move toward bit 0");
  // eighth shift lands on the edge after the run, so done shows then
  a_auto_cycle_len : assert property (
    @(posedge clk) disable iff (!rst_b)
    (auto_shift_enable_q && feedback_ready && !reg_wr && load_now
     && mode_q == bcg_pkg::MODE_LRC8 && !double_byte_select_q)
    ##1 (feedback_ready && !reg_wr)[*8] |=> done_q)
    else $error("auto cycle not eight shifts");
  a_step_one_shift : assert property (
    @(posedge clk) disable iff (!rst_b)
    (!auto_shift_enable_q && !step_cmd) |-> !shift_pulse)
    else $error("shift without step in step mode");
  a_count_bound : assert property (
    @(posedge clk) disable iff (!rst_b)
    count_q < target || done_q)
    else $error("shift count past character length");
  a_unused_zero : assert property (
    @(posedge clk) disable iff (!rst_b)
    $past(reg_rd) && $past(reg_sel) == bcg_pkg::SEL_CTRL
    |-> reg_rdata[15:bcg_pkg::USED_BITS] == '0
        && reg_rdata[bcg_pkg::STEP_BIT:bcg_pkg::CLEAR_BIT] == '0)
    else $error("write-only or unused bits read nonzero");
  a_data_reads_zero : assert property (
    @(posedge clk) disable iff (!rst_b)
    reg_rd && reg_sel == bcg_pkg::SEL_DATA |=> reg_rdata == 16'h0000)
    else $error("data register answered a read");
  c_auto_cycle : cover property (@(posedge clk) disable iff (!rst_b)
    load_now && auto_shift_enable_q ##[1:40] done_q);
  c_step : cover property (@(posedge clk) disable iff (!rst_b)
    step_cmd && shift_now);
  c_fifo_full : cover property (@(posedge clk) disable iff (!rst_b)
    !data_wr_ready);
  c_clear_mid : cover property (@(posedge clk) disable iff (!rst_b)
    clear_cmd && !done_q);
endmodule

// ### bcg_fb_model.sv
// far-side model: feedback network and accumulator stand-in
// assumes the bench drives stall shortly after each rising edge
`timescale 1ns/1ps
module bcg_fb_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // control from the bench
  input  wire logic        stall,
  // design side
  input  wire logic        serial_bit,
  input  wire logic        shift_pulse,
  input  wire logic        accumulator_clear,
  output logic             feedback_ready,
  output logic [15:0]      acc_value,
  output logic             quotient_bit
);
  logic [15:0] acc_q;
  // stalls at will, so the design must hold its bit meanwhile
  assign feedback_ready = !stall;
  assign acc_value      = acc_q;
  assign quotient_bit   = acc_q[0];
  // toy accumulate; the real polynomial network lives elsewhere
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= 16'h0000;
    end else if (accumulator_clear) begin
      acc_q <= 16'h0000;
    end else if (shift_pulse && feedback_ready) begin
      acc_q <= {acc_q[0] ^ serial_bit, acc_q[15:1]};
    end
  end
endmodule

// ### bcg_csr_data_tb_top.sv
// self-checking bench for the register and data register front end
// assumes the far-side model stands in for the accumulator logic
`timescale 1ns/1ps
module bcg_csr_data_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [1:0]  reg_sel = 2'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, acc_value, r;
  logic        data_wr_ready, quotient_bit, feedback_ready, serial_bit;
  logic        shift_pulse, accumulator_clear, wide_check_bit, ok;
  logic [2:0]  poly_mode;
  logic        stall = 1'b0;
  int          smode = 0;
  int          seed = 32'h9267;
  int          miscompares = 0;
  int          cmp_count = 0;
  logic        got[$];
  logic        exp_q[$];
  always #2.5 clk = !clk;
  bcg_csr_data dut_u (.clk(clk), .rst_b(rst_b), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .data_wr_ready(data_wr_ready),
    .acc_value(acc_value), .quotient_bit(quotient_bit),
    .feedback_ready(feedback_ready), .serial_bit(serial_bit),
    .shift_pulse(shift_pulse), .accumulator_clear(accumulator_clear),
    .poly_mode(poly_mode), .wide_check_bit(wide_check_bit));
  bcg_fb_model fb_u (.clk(clk), .rst_b(rst_b), .stall(stall),
    .serial_bit(serial_bit), .shift_pulse(shift_pulse),
    .accumulator_clear(accumulator_clear),
    .feedback_ready(feedback_ready), .acc_value(acc_value),
    .quotient_bit(quotient_bit));
  // stall: 0 never, 1 always, 2 at random
  always @(posedge clk) begin
    #1;
    stall = (smode == 1) || (smode == 2 && ($random(seed) & 3) == 0);
  end
  // strobe is settled mid-cycle and taken at the next rising edge
  always @(negedge clk) begin
    if (shift_pulse === 1'b1) got.push_back(serial_bit);
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    @(posedge clk);
    #1 reg_sel = s;
    reg_wdata = d;
    reg_wr = 1'b1;
    ok = data_wr_ready;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [1:0] s);
    @(posedge clk);
    #1 reg_sel = s;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    r = reg_rdata;
  endtask
  // auto runs fill the buffer under stall; step runs shift by hand
  task automatic run(input logic [2:0] m, input logic d, input bit stp);
    int n, acc, k;
    logic [15:0] w;
    n = ((m == bcg_pkg::MODE_CRC12) ? 6 : 8) * (d ? 2 : 1);
    got.delete();
    exp_q.delete();
    acc = 0;
    smode = stp ? 0 : 1;
    wr(bcg_pkg::SEL_CTRL, {9'h000, !stp, 2'b00, d, m});
    for (k = 0; k < (stp ? 1 : 4); k++) begin
      w = $random(seed);
      wr(bcg_pkg::SEL_DATA, w);
      if (ok === 1'b1) begin
        acc++;
        for (int b = 0; b < n; b++) exp_q.push_back(w[b]);
      end
    end
    chk(acc, stp ? 1 : 3);
    chk(got.size(), 0);
    if (stp) begin
      for (k = 0; k < n; k++) wr(bcg_pkg::SEL_CTRL, {10'h000, 2'b10, d, m});
    end
    // single-character runs drain unstalled so full cycles stay clean
    smode = d ? 2 : 0;
    for (k = 0; k < 500 && got.size() < exp_q.size(); k++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(got.size(), exp_q.size());
    for (k = 0; k < exp_q.size() && k < got.size(); k++)
      chk(got[k], exp_q[k]);
    rd(bcg_pkg::SEL_CTRL);
    chk(r, {7'h00, quotient_bit, 1'b1, !stp, 2'b00, d, m});
    chk({wide_check_bit, poly_mode}, {m[0], m});
    $display("test run mode %0d ddb %0d step %0d done", m, d, stp);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    rd(bcg_pkg::SEL_CTRL);
    chk(r, 16'h0080);
    for (int s = 1; s < 4; s++) begin
      rd(s[1:0]);
      chk(r, (s == 1) ? acc_value : 16'h0000);
    end
    $display("test reset and selects done");
    for (int i = 0; i < 8; i++) begin
      reg_wdata = $random(seed);
      r = reg_wdata & 16'hfffb;  // undefined modes avoided
      wr(bcg_pkg::SEL_CTRL, r);
      chk(accumulator_clear, r[4]);
      chk({wide_check_bit, poly_mode}, {r[0], r[2:0]});
      rd(bcg_pkg::SEL_CTRL);
      chk(r, {7'h00, quotient_bit, 1'b1, reg_wdata[6], 2'b00,
              reg_wdata[3:0]});
    end
    $display("test control fields done");
    for (int m = 0; m < 4; m++) begin
      run(m[2:0], 1'b0, 1'b0);
      run(m[2:0], 1'b1, 1'b0);
      run(m[2:0], m[0], 1'b1);
    end
    smode = 1;
    got.delete();
    wr(bcg_pkg::SEL_CTRL, 16'h0042);
    wr(bcg_pkg::SEL_DATA, 16'h00a5);
    wr(bcg_pkg::SEL_CTRL, 16'h0052);
    chk(accumulator_clear, 1'b1);
    smode = 0;
    rd(bcg_pkg::SEL_ACC);
    chk(r, 16'h0000);
    rd(bcg_pkg::SEL_CTRL);
    chk(r, 16'h00c2);
    chk(got.size(), 0);
    $display("test clear abort done");
    conclude();
  end
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule
